// ### rtl/rsc_defines.svh
// Constants for the reset cause and initial state controller
`ifndef RSC_DEFINES_SVH
`define RSC_DEFINES_SVH
`define RSC_PORT_W        8
`define RSC_PORT_INIT     8'hFF
`define RSC_CTRL_INIT     8'h00
`define RSC_PCL_INIT      8'h00
`define RSC_SP_INIT       3'h0
`define RSC_SP_W          3
`define RSC_INT_W         8
`define RSC_INT_INIT      8'h00
`endif

// ### rtl/rsc_pkg.sv
// Types for the reset cause and initial state controller
package rsc_pkg;
    typedef enum logic [2:0] {
        RSC_SRC_NONE,
        RSC_SRC_POR,
        RSC_SRC_LV,
        RSC_SRC_WDT_RUN,
        RSC_SRC_WDT_HALT
    } rsc_src_t;

    typedef struct packed {
        logic por;
        logic lv;
        logic wdt;
        logic halted;
    } rsc_req_t;

    typedef struct packed {
        logic timeout_flag;
        logic powerdown_flag;
    } rsc_flags_t;

    typedef struct packed {
        logic ports_init;
        logic ctrl_init;
        logic pcl_clear;
        logic sp_clear;
        logic int_disable;
        logic wdt_clear;
    } rsc_load_t;
endpackage

// ### rtl/rsc_prio.sv
// Reset source priority encoder
`timescale 1ns/1ns
module rsc_prio (
    input  wire rsc_pkg::rsc_req_t req,
    output rsc_pkg::rsc_src_t      src
);
    always_comb begin
        if (req.por) begin
            src = rsc_pkg::RSC_SRC_POR;
        end else if (req.lv) begin
            src = rsc_pkg::RSC_SRC_LV;
        end else if (req.wdt && req.halted) begin
            src = rsc_pkg::RSC_SRC_WDT_HALT;
        end else if (req.wdt) begin
            src = rsc_pkg::RSC_SRC_WDT_RUN;
        end else begin
            src = rsc_pkg::RSC_SRC_NONE;
        end
    end
endmodule

// ### rtl/rsc_ctrl.sv
// Reset cause flags and initial register value selection
// What this block does
// - Keep time-out and power-down flags; power-on reset clears both.
// - Low-voltage reset while running leaves both flags unchanged.
// - Watchdog reset while running sets time-out, keeps power-down.
// - Watchdog reset while halted sets both flags.
// - Power-on reset disables every interrupt source.
// - Power-on reset clears watchdog counter; it counts again on release.
// - Power-on, low-voltage, running watchdog resets set port data and direction to ones.
// - Power-on reset sets stack pointer to top of stack.
// - Those three resets load peripheral controls with their reset values.
// - Halted watchdog reset keeps contents, clears program counter low, sets flags.
// - Halted watchdog reset clears program counter and stack pointer, sets time-out.
// - Running watchdog reset acts as low-voltage reset plus time-out set.
`timescale 1ns/1ns
`include "rsc_defines.svh"
module rsc_ctrl #(
    parameter int PORT_W = `RSC_PORT_W
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire logic                    por_req,
    input  wire logic                    low_voltage_reset,
    input  wire logic                    wdt_timeout,
    input  wire logic                    halted,
    input  wire logic                    timeout_clr,
    input  wire logic                    powerdown_set,
    output rsc_pkg::rsc_flags_t          flags,
    output rsc_pkg::rsc_load_t           load,
    output logic [PORT_W-1:0]            port_data_init,
    output logic [PORT_W-1:0]            port_dir_init,
    output logic [7:0]                   ctrl_init_val,
    output logic [7:0]                   program_counter_low,
    output logic [`RSC_SP_W-1:0]         sp_init_val,
    output logic [`RSC_INT_W-1:0]        int_enable_init,
    output rsc_pkg::rsc_src_t            last_src
);
    // Port images are at most one byte wide
    if (PORT_W < 1 || PORT_W > 8) begin : g_port_w_check
        $error("PORT_W must be 1..8");
    end

    typedef struct packed {
        rsc_pkg::rsc_flags_t flags;
        rsc_pkg::rsc_load_t  load;
        rsc_pkg::rsc_src_t   src;
    } rsc_state_t;

    rsc_state_t          state_reg;
    rsc_state_t          state_next;
    rsc_pkg::rsc_src_t   src;
    rsc_pkg::rsc_req_t   req;

    assign req = '{por: por_req, lv: low_voltage_reset, wdt: wdt_timeout, halted: halted};

    rsc_prio u_prio (
        .req (req),
        .src (src)
    );

    always_comb begin
        state_next = state_reg;
        state_next.load = '0;
        state_next.src = src;
        // Software side: time-out clear by watchdog clear, power-down set by halt
        if (timeout_clr) begin
            state_next.flags.timeout_flag = 1'b0;
        end
        if (powerdown_set) begin
            state_next.flags.powerdown_flag = 1'b1;
        end
        case (src)
            rsc_pkg::RSC_SRC_POR: begin
                state_next.flags = '0;
                state_next.load = '1;
            end
            rsc_pkg::RSC_SRC_LV: begin
                // Reset wins over same-cycle software flag change
                state_next.flags = state_reg.flags;
                state_next.load.ports_init = 1'b1;
                state_next.load.ctrl_init = 1'b1;
                state_next.load.pcl_clear = 1'b1;
                state_next.load.int_disable = 1'b1;
            end
            rsc_pkg::RSC_SRC_WDT_RUN: begin
                state_next.flags.timeout_flag = 1'b1;
                state_next.flags.powerdown_flag = state_reg.flags.powerdown_flag;
                state_next.load.ports_init = 1'b1;
                state_next.load.ctrl_init = 1'b1;
                state_next.load.pcl_clear = 1'b1;
                state_next.load.int_disable = 1'b1;
            end
            rsc_pkg::RSC_SRC_WDT_HALT: begin
                // Reset wins over any same-cycle software flag change
                state_next.flags.timeout_flag = 1'b1;
                state_next.flags.powerdown_flag = 1'b1;
                state_next.load.pcl_clear = 1'b1;
                state_next.load.sp_clear = 1'b1;
            end
            rsc_pkg::RSC_SRC_NONE: begin
            end
            default: begin
            end
        endcase
    end

    // Async reset is the power-on path itself
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= '{flags: '0, load: '1, src: rsc_pkg::RSC_SRC_POR};
        end else begin
            state_reg <= state_next;
        end
    end

    assign flags               = state_reg.flags;
    assign load                = state_reg.load;
    assign last_src            = state_reg.src;
    assign port_data_init      = {PORT_W{1'b1}};
    assign port_dir_init       = {PORT_W{1'b1}};
    assign ctrl_init_val       = `RSC_CTRL_INIT;
    assign program_counter_low = `RSC_PCL_INIT;
    assign sp_init_val         = `RSC_SP_INIT;
    assign int_enable_init     = `RSC_INT_INIT;
endmodule

// ### verification/rsc_ctrl_asserts.sv
// Port assertions for the reset cause controller
`timescale 1ns/1ns
module rsc_ctrl_asserts (
    input wire logic           clk,
    input wire logic           rstn,
    input wire logic           por_req,
    input wire logic           low_voltage_reset,
    input wire logic           wdt_timeout,
    input wire logic           halted,
    input rsc_pkg::rsc_flags_t flags,
    input rsc_pkg::rsc_load_t  load,
    input rsc_pkg::rsc_src_t   last_src
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Sampled rstn keeps checks off the edge that releases reset
    wire por_hit = rstn && por_req;
    wire lv_hit  = rstn && low_voltage_reset && !por_req;
    wire wdt_hit = rstn && wdt_timeout && !por_req && !low_voltage_reset;
    por_load_a: assert property (por_hit |=>
        flags == 2'h0 && load == 6'h3F)
        else $error("power-on loads wrong");
    lv_keep_a: assert property (lv_hit |=>
        $stable(flags) && load == 6'h3A)
        else $error("low-voltage loads wrong");
    wdt_run_a: assert property (wdt_hit && !halted |=>
        flags.timeout_flag && load == 6'h3A)
        else $error("running time-out wrong");
    run_pd_a: assert property (wdt_hit && !halted |=>
        $stable(flags.powerdown_flag))
        else $error("running time-out moved powerdown");
    wdt_halt_a: assert property (wdt_hit && halted |=>
        flags == 2'h3 && load == 6'h0C)
        else $error("halted time-out wrong");
    idle_load_a: assert property (rstn && !(por_req || low_voltage_reset || wdt_timeout) |=>
        load == 6'h00)
        else $error("load without cause");
    por_src_a: assert property (por_hit |=>
        last_src == rsc_pkg::RSC_SRC_POR)
        else $error("power-on not first");
    lv_src_a: assert property (lv_hit && wdt_timeout |=>
        last_src == rsc_pkg::RSC_SRC_LV)
        else $error("low-voltage not above time-out");
    cover property (wdt_hit && halted);
    cover property (lv_hit && wdt_timeout);
    cover property (por_hit && low_voltage_reset);
endmodule

// ### verification/rsc_ctrl_test.sv
// Scenario bench for the reset cause controller
`timescale 1ns/1ns
module rsc_ctrl_test;
    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic [5:0]          in_v = 6'h00;
    logic                por_req, low_voltage_reset, wdt_timeout, halted;
    logic                timeout_clr, powerdown_set;
    rsc_pkg::rsc_flags_t flags;
    rsc_pkg::rsc_load_t  load;
    rsc_pkg::rsc_src_t   last_src;
    logic [7:0]          port_data_init, port_dir_init, ctrl_init_val;
    logic [7:0]          program_counter_low, int_enable_init;
    logic [2:0]          sp_init_val;
    int                  failures = 0;
    int                  samples_checked = 0;
    assign {por_req, low_voltage_reset, wdt_timeout, halted, timeout_clr, powerdown_set} = in_v;
    always #50 clk = ~clk;
    rsc_ctrl dut_u (
        .clk                 (clk),
        .rstn                (rstn),
        .por_req             (por_req),
        .low_voltage_reset   (low_voltage_reset),
        .wdt_timeout         (wdt_timeout),
        .halted              (halted),
        .timeout_clr         (timeout_clr),
        .powerdown_set       (powerdown_set),
        .flags               (flags),
        .load                (load),
        .port_data_init      (port_data_init),
        .port_dir_init       (port_dir_init),
        .ctrl_init_val       (ctrl_init_val),
        .program_counter_low (program_counter_low),
        .sp_init_val         (sp_init_val),
        .int_enable_init     (int_enable_init),
        .last_src            (last_src)
    );
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) failures++;
        if (got !== exp) $display("ERROR %0t got %h want %h", $time, got, exp);
    endtask
    // One cause cycle, then idle; outputs judged after the answering edge
    task go(input logic [5:0] v, input logic [1:0] f, input logic [5:0] l);
        @(posedge clk) in_v <= v;
        @(posedge clk) in_v <= 6'h00;
        #1 chk(flags, f);
        chk(load, l);
    endtask
    task halt_then_lv;
        go(6'h0C, 2'b11, 6'h0C);
        chk(program_counter_low, 8'h00);
        go(6'h10, 2'b11, 6'h3A);
        chk(port_data_init, 8'hFF);
        chk(port_dir_init, 8'hFF);
        chk(ctrl_init_val, 8'h00);
    endtask
    task por_then_run;
        go(6'h20, 2'b00, 6'h3F);
        chk(int_enable_init, 8'h00);
        chk(sp_init_val, 8'h00);
        go(6'h08, 2'b10, 6'h3A);
    endtask
    task coinciding;
        go(6'h3E, 2'b00, 6'h3F);
        chk(last_src, rsc_pkg::RSC_SRC_POR);
        go(6'h01, 2'b01, 6'h00);
        go(6'h1E, 2'b01, 6'h3A);
        go(6'h0E, 2'b11, 6'h0C);
    endtask
    // Software flag changes racing a reset cause lose to it
    task sw_race;
        go(6'h1A, 2'h3, 6'h3A);
        go(6'h20, 2'h0, 6'h3F);
        go(6'h09, 2'h2, 6'h3A);
        go(6'h02, 2'h0, 6'h00);
    endtask
    // Mid-run power-on through the asynchronous reset pin
    task mid_reset;
        go(6'h01, 2'h1, 6'h00);
        @(posedge clk) rstn <= 1'b0;
        #1 chk(flags, 2'h0);
        chk(load, 6'h3F);
        chk(last_src, rsc_pkg::RSC_SRC_POR);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk) #1 chk(load, 6'h00);
        chk(flags, 2'h0);
    endtask
    task report_and_stop;
        if (failures == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        halt_then_lv;
        por_then_run;
        coinciding;
        sw_race;
        mid_reset;
        report_and_stop;
    end
    // About 38 cycles needed; wide margin
    initial begin
        #20000;
        failures++;
        report_and_stop;
    end
endmodule
bind rsc_ctrl rsc_ctrl_asserts chk_u (
    .clk               (clk),
    .rstn              (rstn),
    .por_req           (por_req),
    .low_voltage_reset (low_voltage_reset),
    .wdt_timeout       (wdt_timeout),
    .halted            (halted),
    .flags             (flags),
    .load              (load),
    .last_src          (last_src)
);
